// [hw/dsu_pkg.sv]
package dsu_pkg;
    // Register index; byte address is four times the index
    localparam logic [7:0] DSU_IDX_CMD = 8'h00;
    localparam logic [7:0] DSU_IDX_STA = 8'h01;
    localparam logic [7:0] DSU_IDX_LIVE = 8'h02;
    localparam logic [7:0] DSU_IDX_ADDR = 8'h04;
    localparam logic [7:0] DSU_IDX_LEN = 8'h08;
    localparam logic [7:0] DSU_IDX_DATA = 8'h0c;
    localparam logic [7:0] DSU_IDX_MB0 = 8'h10;
    localparam logic [7:0] DSU_IDX_MB1 = 8'h14;
    // Command bits
    localparam int DSU_CMD_ERASE = 4;
    localparam int DSU_CMD_BIST = 3;
    localparam int DSU_CMD_CRC = 2;
    localparam int DSU_CMD_MODULE_SOFT_RESET = 0;
    // Sticky status bits
    localparam int DSU_STA_PROTECTION_ERROR_FLAG = 4;
    localparam int DSU_STA_FAIL = 3;
    localparam int DSU_STA_BUS_ERROR_FLAG = 2;
    localparam int DSU_STA_CRST = 1;
    localparam int DSU_STA_DONE = 0;
    // Live status bits
    localparam int DSU_LIVE_HPE = 4;
    localparam int DSU_LIVE_DIRTY0 = 2;
    localparam int DSU_LIVE_DBG = 1;
    localparam int DSU_LIVE_SECURED_STATE_FLAG = 0;
    // Reset values and constants
    localparam logic [4:0] DSU_STA_RST = 5'h00;
    localparam logic [31:0] DSU_WORD_RST = 32'h0000_0000;
    localparam logic [29:0] DSU_LEN_RST = 30'h0000_0000;
    localparam logic [1:0] DSU_DIRTY_RST = 2'h0;
    localparam logic HPE_RST = 1'b1;
    localparam logic [31:0] DSU_CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] DSU_BIST_SEED = 32'h5555_aaaa;
    typedef enum {E_IDLE, E_ERASE, E_ACCESS} dsu_eng_e;
endpackage : dsu_pkg

// [hw/dsu_crc_step.sv]
`timescale 1ns/1ps
`default_nettype none
module dsu_crc_step
    import dsu_pkg::*;
(
    input wire logic [31:0] crc_in, // Running remainder
    input wire logic [31:0] word, // Word fed in
    output logic [31:0] crc_out // Remainder after word
);
    logic [31:0] stage [0:32];
    assign stage[0] = crc_in ^ word;
    // One reflected shift per bit
    for (genvar b = 0; b < 32; b++)
    begin : g_bit
        assign stage[b+1] = stage[b][0] ? ((stage[b] >> 1) ^ DSU_CRC_POLY) : (stage[b] >> 1);
    end
    assign crc_out = stage[32];
endmodule : dsu_crc_step
`default_nettype wire

// [hw/dsu_mailbox.sv]
`timescale 1ns/1ps
`default_nettype none
module dsu_mailbox
    import dsu_pkg::*;
#(
    parameter int N = 2
)(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, low
    input wire logic clr, // Soft reset
    input wire logic [N-1:0] we, // Entry write
    input wire logic [3:0] strb, // Byte lanes
    input wire logic [31:0] wdata, // Write data
    input wire logic rd_en, // Capture read data
    input wire logic [$clog2(N)-1:0] rd_sel, // Entry read
    output logic [31:0] rdata_ff // Registered read data
);
    logic [31:0] mem_ff [N];
    logic [31:0] nxt_mem [N];
    logic [31:0] nxt_rdata;
    for (genvar i = 0; i < N; i++)
    begin : g_ent
        always_comb
        begin
            nxt_mem[i] = mem_ff[i];
            if (clr)
                nxt_mem[i] = DSU_WORD_RST;
            else if (we[i])
                for (int k = 0; k < 4; k++)
                    if (strb[k])
                        nxt_mem[i][8*k +: 8] = wdata[8*k +: 8];
        end
        always_ff @(posedge pclk or negedge presetn)
            if (!presetn)
                mem_ff[i] <= DSU_WORD_RST;
            else
                mem_ff[i] <= nxt_mem[i];
    end
    always_comb
        nxt_rdata = rd_en ? mem_ff[rd_sel] : rdata_ff;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            rdata_ff <= DSU_WORD_RST;
        else
            rdata_ff <= nxt_rdata;
endmodule : dsu_mailbox
`default_nettype wire

// [hw/dsu_reg_bank.sv]
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dsu_reg_bank
    import dsu_pkg::*;
#(
    parameter int AW = 12
)(
    input wire logic pclk, // Clock, 40 MHz
    input wire logic presetn, // Async reset, low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [AW-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error
    input wire logic guard_protect, // Access guard on
    input wire logic secured_strap, // Device protected
    input wire logic probe_detect, // Debugger seen
    input wire logic cold_plug, // Cold plug pulse
    input wire logic swclk_fn_change, // Clock pin reassigned
    output logic cpu_reset_extend, // Hold CPU reset
    output logic erase_req, // Chip erase request
    input wire logic erase_ack, // Erase finished
    input wire logic erase_fail, // Erase failed
    output logic mem_req, // Memory request
    output logic mem_we, // Memory write
    output logic [31:0] mem_addr, // Memory byte address
    output logic [1:0] mem_amode, // Access mode field
    output logic [31:0] mem_wdata, // Memory write data
    input wire logic mem_ack, // Memory done
    input wire logic mem_err, // Memory bus error
    input wire logic [31:0] mem_rdata, // Memory read data
    output logic busy // Operation running
);
    logic pready_ff, pslverr_ff, nxt_pready, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic [4:0] sta_ff, nxt_sta, sta_set, sta_clr;
    logic [31:0] addr_ff, nxt_addr, data_ff, nxt_data;
    logic [29:0] len_ff, nxt_len;
    logic [1:0] dirty_ff, nxt_dirty;
    logic dbg_ff, secured_state_flag_ff, hpe_ff, init_ff;
    logic nxt_dbg, nxt_secured_state_flag, nxt_hpe;
    dsu_eng_e st_ff, nxt_st;
    logic [29:0] cnt_ff, nxt_cnt, ptr_ff, nxt_ptr;
    logic bist_ff, nxt_bist, wr_ph_ff, nxt_wr_ph;
    logic busy_ff;
    logic req_ff, nxt_req, we_ff, nxt_we, erase_ff, nxt_erase;
    logic [31:0] wdata_ff, nxt_wdata, crc_next, mb_rdata, pattern;
    logic setup, acc_first, commit, hit, guarded, wr_ok, wr;
    logic [7:0] idx;
    logic cmd_wr, module_soft_reset, go_erase, go_bist, go_crc;

    assign setup = psel && !penable;
    assign acc_first = psel && penable && !pready_ff;
    assign commit = psel && penable && pready_ff;
    assign idx = paddr[9:2];
    always_comb
    begin
        hit = (paddr[1:0] == 2'b00) && (paddr[AW-1:10] == '0);
        case (idx)
            DSU_IDX_CMD, DSU_IDX_STA, DSU_IDX_LIVE, DSU_IDX_ADDR,
            DSU_IDX_LEN, DSU_IDX_DATA, DSU_IDX_MB0, DSU_IDX_MB1: ;
            default: hit = 1'b0;
        endcase
    end
    assign guarded = hit && idx != DSU_IDX_MB0 && idx != DSU_IDX_MB1;
    assign wr_ok = !(guard_protect && guarded);
    assign wr = commit && pwrite && hit && wr_ok;

    // Command pulses, never stored
    assign cmd_wr = wr && idx == DSU_IDX_CMD && pstrb[0];
    assign module_soft_reset = cmd_wr && pwdata[DSU_CMD_MODULE_SOFT_RESET];
    assign go_erase = cmd_wr && pwdata[DSU_CMD_ERASE];
    assign go_bist = cmd_wr && pwdata[DSU_CMD_BIST];
    assign go_crc = cmd_wr && pwdata[DSU_CMD_CRC];
    assign pattern = {ptr_ff, 2'b00} ^ DSU_BIST_SEED;

    dsu_crc_step u_crc (
        .crc_in(data_ff),
        .word(mem_rdata),
        .crc_out(crc_next)
    );

    dsu_mailbox #(.N(2)) u_mb (
        .pclk(pclk),
        .presetn(presetn),
        .clr(module_soft_reset),
        .we({wr && idx == DSU_IDX_MB1, wr && idx == DSU_IDX_MB0}),
        .strb(pstrb),
        .wdata(pwdata),
        .rd_en(setup),
        .rd_sel(idx == DSU_IDX_MB1),
        .rdata_ff(mb_rdata)
    );

    // APB slave: one wait state, read data captured in it
    always_comb
    begin
        nxt_pready = acc_first;
        nxt_pslverr = pslverr_ff;
        nxt_prdata = prdata_ff;
        if (acc_first)
        begin
            nxt_pslverr = !hit || (pwrite && !wr_ok);
            nxt_prdata = '0;
            case (idx)
                DSU_IDX_STA: nxt_prdata = {27'h0, sta_ff};
                DSU_IDX_LIVE: nxt_prdata = {27'h0, hpe_ff, dirty_ff, dbg_ff, secured_state_flag_ff};
                DSU_IDX_ADDR: nxt_prdata = addr_ff;
                DSU_IDX_LEN: nxt_prdata = {len_ff, 2'b00};
                DSU_IDX_DATA: nxt_prdata = data_ff;
                DSU_IDX_MB0, DSU_IDX_MB1: nxt_prdata = mb_rdata;
                default: nxt_prdata = '0;
            endcase
            if (pwrite || !hit)
                nxt_prdata = '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= DSU_WORD_RST;
        end
        else
        begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign prdata = prdata_ff;

    // Operation engine and software-written registers
    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_ptr = ptr_ff;
        nxt_bist = bist_ff;
        nxt_wr_ph = wr_ph_ff;
        nxt_req = req_ff;
        nxt_we = we_ff;
        nxt_wdata = wdata_ff;
        nxt_erase = erase_ff;
        nxt_addr = addr_ff;
        nxt_len = len_ff;
        nxt_data = data_ff;
        sta_set = '0;
        sta_clr = '0;
        if (wr && st_ff == E_IDLE)
            for (int k = 0; k < 4; k++)
                if (pstrb[k])
                begin
                    if (idx == DSU_IDX_ADDR)
                        nxt_addr[8*k +: 8] = pwdata[8*k +: 8];
                    if (idx == DSU_IDX_DATA)
                        nxt_data[8*k +: 8] = pwdata[8*k +: 8];
                    if (idx == DSU_IDX_LEN && k > 0)
                        nxt_len[8*k-2 +: 8] = pwdata[8*k +: 8];
                end
        if (wr && idx == DSU_IDX_LEN && st_ff == E_IDLE && pstrb[0])
            nxt_len[5:0] = pwdata[7:2];
        if (wr && idx == DSU_IDX_STA && pstrb[0])
            sta_clr = pwdata[4:0];
        if (cold_plug)
            sta_set[DSU_STA_CRST] = 1'b1;
        case (st_ff)
            E_IDLE:
                if (go_erase)
                begin
                    nxt_erase = 1'b1;
                    nxt_st = E_ERASE;
                end
                else if ((go_bist || go_crc) && secured_state_flag_ff)
                    sta_set[DSU_STA_PROTECTION_ERROR_FLAG] = 1'b1;
                else if (go_bist || go_crc)
                begin
                    nxt_bist = go_bist;
                    nxt_ptr = addr_ff[31:2];
                    nxt_cnt = len_ff;
                    if (len_ff == '0)
                        sta_set[DSU_STA_DONE] = 1'b1;
                    else
                    begin
                        nxt_req = 1'b1;
                        nxt_we = go_bist;
                        nxt_wr_ph = go_bist;
                        nxt_wdata = {addr_ff[31:2], 2'b00} ^ DSU_BIST_SEED;
                        nxt_st = E_ACCESS;
                    end
                end
            E_ERASE:
                if (erase_ack)
                begin
                    nxt_erase = 1'b0;
                    nxt_st = E_IDLE;
                    sta_set[DSU_STA_FAIL] = erase_fail;
                    sta_set[DSU_STA_DONE] = !erase_fail;
                end
            E_ACCESS:
                if (mem_ack)
                begin
                    nxt_req = 1'b0;
                    nxt_we = 1'b0;
                    if (mem_err)
                    begin
                        sta_set[DSU_STA_BUS_ERROR_FLAG] = 1'b1;
                        nxt_st = E_IDLE;
                    end
                    else if (bist_ff && wr_ph_ff)
                    begin
                        nxt_req = 1'b1;
                        nxt_wr_ph = 1'b0;
                    end
                    else if (bist_ff && mem_rdata != pattern)
                    begin
                        sta_set[DSU_STA_FAIL] = 1'b1;
                        nxt_st = E_IDLE;
                    end
                    else
                    begin
                        if (!bist_ff)
                            nxt_data = crc_next;
                        nxt_cnt = cnt_ff - 30'h1;
                        nxt_ptr = ptr_ff + 30'h1;
                        if (cnt_ff == 30'h1)
                        begin
                            sta_set[DSU_STA_DONE] = 1'b1;
                            nxt_st = E_IDLE;
                        end
                        else
                        begin
                            nxt_req = 1'b1;
                            nxt_we = bist_ff;
                            nxt_wr_ph = bist_ff;
                            nxt_wdata = {ptr_ff + 30'h1, 2'b00} ^ DSU_BIST_SEED;
                        end
                    end
                end
            default: nxt_st = E_IDLE;
        endcase
        nxt_sta = (sta_ff & ~sta_clr) | sta_set;
        if (module_soft_reset)
        begin
            nxt_st = E_IDLE;
            nxt_req = 1'b0;
            nxt_we = 1'b0;
            nxt_erase = 1'b0;
            nxt_addr = DSU_WORD_RST;
            nxt_len = DSU_LEN_RST;
            nxt_data = DSU_WORD_RST;
            nxt_sta = DSU_STA_RST;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            st_ff <= E_IDLE;
            cnt_ff <= DSU_LEN_RST;
            ptr_ff <= DSU_LEN_RST;
            bist_ff <= 1'b0;
            wr_ph_ff <= 1'b0;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            wdata_ff <= DSU_WORD_RST;
            erase_ff <= 1'b0;
            addr_ff <= DSU_WORD_RST;
            len_ff <= DSU_LEN_RST;
            data_ff <= DSU_WORD_RST;
            sta_ff <= DSU_STA_RST;
            busy_ff <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            ptr_ff <= nxt_ptr;
            bist_ff <= nxt_bist;
            wr_ph_ff <= nxt_wr_ph;
            req_ff <= nxt_req;
            we_ff <= nxt_we;
            wdata_ff <= nxt_wdata;
            erase_ff <= nxt_erase;
            addr_ff <= nxt_addr;
            len_ff <= nxt_len;
            data_ff <= nxt_data;
            sta_ff <= nxt_sta;
            busy_ff <= (nxt_st != E_IDLE);
        end
    assign mem_req = req_ff;
    assign mem_we = we_ff;
    assign mem_addr = {ptr_ff, 2'b00};
    assign mem_amode = addr_ff[1:0];
    assign mem_wdata = wdata_ff;
    assign erase_req = erase_ff;
    assign busy = busy_ff;
    assign cpu_reset_extend = sta_ff[DSU_STA_CRST];

    // Live status: LIVE writes ignored; dirty bits follow mailbox accesses and soft reset
    always_comb
    begin
        nxt_dirty = dirty_ff;
        for (int i = 0; i < 2; i++)
        begin
            if (commit && hit && !pwrite && idx == DSU_IDX_MB0 + 8'(4 * i))
                nxt_dirty[i] = 1'b0;
            if (wr && idx == DSU_IDX_MB0 + 8'(4 * i))
                nxt_dirty[i] = 1'b1;
        end
        if (module_soft_reset)
            nxt_dirty = DSU_DIRTY_RST;
        nxt_dbg = dbg_ff || probe_detect;
        nxt_hpe = hpe_ff && !swclk_fn_change;
        nxt_secured_state_flag = init_ff ? secured_state_flag_ff : secured_strap;
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            dirty_ff <= DSU_DIRTY_RST;
            dbg_ff <= 1'b0;
            hpe_ff <= HPE_RST;
            secured_state_flag_ff <= 1'b0;
            init_ff <= 1'b0;
        end
        else
        begin
            dirty_ff <= nxt_dirty;
            dbg_ff <= nxt_dbg;
            hpe_ff <= nxt_hpe;
            secured_state_flag_ff <= nxt_secured_state_flag;
            init_ff <= 1'b1;
        end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RSVD_ZERO: assert property (pready && !pwrite && hit && (idx == DSU_IDX_STA ||
        idx == DSU_IDX_LIVE || idx == DSU_IDX_CMD) |-> prdata[31:5] == '0)
        else $error("reserved bits not zero");
    AST_GUARD: assert property (commit && pwrite && guard_protect && idx == DSU_IDX_ADDR
        && !module_soft_reset |=> addr_ff == $past(addr_ff))
        else $error("guarded write took effect");
    AST_ERASE: assert property (go_erase && st_ff == E_IDLE && !module_soft_reset
        |=> erase_req ##0 busy)
        else $error("erase not started");
    AST_BIST: assert property (go_bist && !go_erase && !secured_state_flag_ff && st_ff == E_IDLE
        && len_ff != '0 && !module_soft_reset |=> mem_req && mem_we)
        else $error("self-test did not write first");
    AST_PROTECTION_ERROR_FLAG: assert property (go_crc && !go_erase && secured_state_flag_ff && st_ff == E_IDLE && !module_soft_reset
        |=> sta_ff[DSU_STA_PROTECTION_ERROR_FLAG] && !busy)
        else $error("protection error not flagged");
    AST_W1C: assert property (wr && idx == DSU_IDX_STA && pstrb[0] && pwdata[0]
        && st_ff == E_IDLE |=> !sta_ff[DSU_STA_DONE])
        else $error("done flag not cleared");
    AST_DIRTY: assert property (wr && idx == DSU_IDX_MB0 |=> dirty_ff[0] ##1 dirty_ff[0]
        || $past(commit))
        else $error("mailbox dirty not set");
    AST_SECURED_STATE_FLAG: assert property (init_ff |=> secured_state_flag_ff == $past(secured_state_flag_ff))
        else $error("protected flag changed");
    AST_DBG: assert property (dbg_ff |=> dbg_ff)
        else $error("debugger flag cleared");
    AST_MODULE_SOFT_RESET: assert property (module_soft_reset |=> addr_ff == '0 && sta_ff == '0 && !busy)
        else $error("soft reset incomplete");
    AST_BUS_ERROR_FLAG: assert property (st_ff == E_ACCESS && mem_ack && mem_err && !module_soft_reset
        |=> sta_ff[DSU_STA_BUS_ERROR_FLAG] && !busy && !mem_req)
        else $error("bus error not flagged");
    COV_ERASE: cover property (erase_req ##[1:20] sta_ff[DSU_STA_DONE]);
    COV_CRC: cover property (go_crc && !secured_state_flag_ff ##[2:60] sta_ff[DSU_STA_DONE]);
    COV_MB: cover property (dirty_ff[1] ##[1:10] !dirty_ff[1]);
endmodule : dsu_reg_bank
`default_nettype wire

// [sim/dsu_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dsu_mem_model
    import dsu_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, low
    input wire logic slow, // Answer late
    input wire logic inj_err, // Answer with error
    input wire logic mem_req, // Request
    input wire logic mem_we, // Write
    input wire logic [31:0] mem_addr, // Byte address
    input wire logic [31:0] mem_wdata, // Write data
    output logic mem_ack, // Done
    output logic mem_err, // Bus error
    output logic [31:0] mem_rdata, // Read data
    input wire logic erase_req, // Erase request
    output logic erase_ack, // Erase done
    output logic erase_fail // Erase failed
);
    logic [31:0] mem [logic [31:0]];
    int cnt;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {mem_ack, mem_err, erase_ack, erase_fail} <= 4'h0;
            mem_rdata <= 32'h0;
            cnt <= 0;
        end
        else
        begin
            {mem_ack, mem_err, erase_ack, erase_fail} <= 4'h0;
            // Read data is junk outside the answer cycle
            mem_rdata <= ~mem_rdata;
            if ((mem_req && !mem_ack) || (erase_req && !erase_ack))
            begin
                cnt <= cnt + 1;
                if (cnt >= (slow ? 3 : 0))
                begin
                    cnt <= 0;
                    if (erase_req)
                    begin
                        erase_ack <= 1'b1;
                        erase_fail <= inj_err;
                    end
                    else
                    begin
                        mem_ack <= 1'b1;
                        mem_err <= inj_err;
                        if (mem_we)
                            mem[mem_addr] = mem_wdata;
                        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : mem_addr ^ 32'h3c3c_1e1e;
                    end
                end
            end
        end
    end
endmodule : dsu_mem_model
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dsu_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, mem_addr, mem_wdata, mem_rdata;
    logic [3:0] pstrb = 0;
    logic guard_protect = 0, secured_strap = 0, slow = 0, inj_err = 0;
    logic [2:0] ev = 0;
    logic cpu_reset_extend, erase_req, erase_ack, erase_fail, mem_req, mem_we, mem_ack, mem_err, busy;
    logic [1:0] mem_amode;
    logic [33:0] expq[$];
    logic [7:0] regs[5] = '{DSU_IDX_ADDR, DSU_IDX_LEN, DSU_IDX_DATA, DSU_IDX_MB0, DSU_IDX_MB1};
    int fail_count = 0, checked = 0;
    integer seed = 32'h59548c54;
    dsu_reg_bank u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .pready, .prdata, .pslverr, .guard_protect, .secured_strap, .probe_detect(ev[1]),
        .cold_plug(ev[0]), .swclk_fn_change(ev[2]), .cpu_reset_extend, .erase_req, .erase_ack,
        .erase_fail, .mem_req, .mem_we, .mem_addr, .mem_amode, .mem_wdata, .mem_ack, .mem_err,
        .mem_rdata, .busy);
    dsu_mem_model u_mem (.pclk, .presetn, .slow, .inj_err, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_err, .mem_rdata, .erase_req, .erase_ack, .erase_fail);
    always #12.5 pclk = ~pclk;
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic hang(input int n);
        if (n >= 2000)
        begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask : hang
    // Expected answers are queued here and matched in the monitor
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
        input logic [3:0] st, input logic err);
        int n;
        expq.push_back({~w, err, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= w ? d : 32'h0;
        pstrb <= w ? st : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 2000);
        hang(n);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic err);
        apb(1'b1, idx, d, 4'hf, err);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [31:0] d, input logic err);
        apb(1'b0, idx, d, 4'h0, err);
    endtask : rd
    task automatic cmd_wait(input int b);
        int n;
        wr(DSU_IDX_CMD, 32'h1 << b, 1'b0);
        n = 0;
        repeat (2) @(posedge pclk);
        while (busy !== 1'b0 && n < 2000)
        begin
            @(posedge pclk);
            n++;
        end
        hang(n);
    endtask : cmd_wait
    task automatic pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev <= 3'h0;
        repeat (2) @(posedge pclk);
    endtask : pulse
    task automatic do_reset(input logic sec);
        presetn <= 1'b0;
        secured_strap <= sec;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    function automatic logic [31:0] crc_of(input logic [31:0] c, input logic [31:0] a, input int n);
        for (int w = 0; w < n; w++)
        begin
            c ^= (a + 32'(4 * w)) ^ 32'h3c3c_1e1e;
            for (int b = 0; b < 32; b++)
                c = c[0] ? (c >> 1) ^ DSU_CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc_of
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
        begin
            logic [33:0] e;
            e = expq.pop_front();
            chk({31'h0, pslverr}, {31'h0, e[32]});
            if (e[33])
                chk(prdata, e[31:0]);
        end
    initial
    begin
        logic [31:0] r;
        do_reset(1'b0);
        rd(DSU_IDX_STA, 32'h0, 1'b0);
        rd(DSU_IDX_LIVE, 32'h10, 1'b0);
        foreach (regs[i])
        begin
            rd(regs[i], 32'h0, 1'b0);
            r = $random(seed);
            wr(regs[i], r, 1'b0);
            if (regs[i] == DSU_IDX_ADDR)
                chk({30'h0, mem_amode}, {30'h0, r[1:0]});
            rd(regs[i], regs[i] == DSU_IDX_LEN ? {r[31:2], 2'b00} : r, 1'b0);
        end
        wr(DSU_IDX_MB1, r, 1'b0);
        rd(DSU_IDX_LIVE, 32'h18, 1'b0);
        rd(DSU_IDX_MB1, r, 1'b0);
        wr(DSU_IDX_LIVE, 32'h1f, 1'b0);
        rd(DSU_IDX_LIVE, 32'h10, 1'b0);
        rd(DSU_IDX_CMD, 32'h0, 1'b0);
        rd(8'h03, 32'h0, 1'b1);
        wr(DSU_IDX_DATA, 32'hffff_ffff, 1'b0);
        apb(1'b1, DSU_IDX_DATA, 32'h00ab_0000, 4'h4, 1'b0);
        rd(DSU_IDX_DATA, 32'hffab_ffff, 1'b0);
        wr(DSU_IDX_ADDR, 32'h100, 1'b0);
        wr(DSU_IDX_LEN, 32'h8, 1'b0);
        wr(DSU_IDX_DATA, r, 1'b0);
        cmd_wait(DSU_CMD_CRC);
        rd(DSU_IDX_DATA, crc_of(r, 32'h100, 2), 1'b0);
        rd(DSU_IDX_STA, 32'h1, 1'b0);
        wr(DSU_IDX_STA, 32'h1, 1'b0);
        rd(DSU_IDX_STA, 32'h0, 1'b0);
        slow <= 1'b1;
        cmd_wait(DSU_CMD_ERASE);
        rd(DSU_IDX_STA, 32'h1, 1'b0);
        inj_err <= 1'b1;
        wr(DSU_IDX_STA, 32'h1f, 1'b0);
        cmd_wait(DSU_CMD_ERASE);
        rd(DSU_IDX_STA, 32'h8, 1'b0);
        {slow, inj_err} <= 2'b00;
        wr(DSU_IDX_STA, 32'h1f, 1'b0);
        wr(DSU_IDX_ADDR, 32'h200, 1'b0);
        wr(DSU_IDX_LEN, 32'hc, 1'b0);
        cmd_wait(DSU_CMD_BIST);
        rd(DSU_IDX_STA, 32'h1, 1'b0);
        inj_err <= 1'b1;
        wr(DSU_IDX_STA, 32'h1f, 1'b0);
        cmd_wait(DSU_CMD_BIST);
        rd(DSU_IDX_STA, 32'h4, 1'b0);
        inj_err <= 1'b0;
        wr(DSU_IDX_STA, 32'h1f, 1'b0);
        guard_protect <= 1'b1;
        wr(DSU_IDX_ADDR, 32'h55, 1'b1);
        rd(DSU_IDX_ADDR, 32'h200, 1'b0);
        wr(DSU_IDX_MB0, r, 1'b0);
        guard_protect <= 1'b0;
        pulse(0);
        rd(DSU_IDX_STA, 32'h2, 1'b0);
        chk({31'h0, cpu_reset_extend}, 32'h1);
        wr(DSU_IDX_STA, 32'h2, 1'b0);
        chk({31'h0, cpu_reset_extend}, 32'h0);
        cmd_wait(DSU_CMD_MODULE_SOFT_RESET);
        rd(DSU_IDX_LIVE, 32'h10, 1'b0);
        rd(DSU_IDX_MB0, 32'h0, 1'b0);
        do_reset(1'b1);
        rd(DSU_IDX_LIVE, 32'h11, 1'b0);
        cmd_wait(DSU_CMD_CRC);
        rd(DSU_IDX_STA, 32'h10, 1'b0);
        pulse(1);
        rd(DSU_IDX_LIVE, 32'h13, 1'b0);
        pulse(2);
        cmd_wait(DSU_CMD_MODULE_SOFT_RESET);
        rd(DSU_IDX_LIVE, 32'h3, 1'b0);
        final_report();
    end
endmodule : testbench
`default_nettype wire
